// ==== bench/acff_partner.sv ====
// stream source and sink models standing on both sides of the channel queue
`default_nettype none
module acff_partner
    import acff_pkg::*;
(
    input wire logic i_mclk,
    input wire logic i_rst_n,
    input wire logic i_src_en,
    input wire logic i_sink_en,
    input wire logic [31:0] i_rnd,
    input wire logic i_s_ready,
    output acff_word_s o_s_word,
    output logic o_s_valid,
    output logic o_m_ready
);
    timeunit 1ns;
    timeprecision 1ps;
    // ******************************
    // upstream source and downstream sink
    // ******************************
    // an offered word stays until taken; a released bus inverts its word on every cycle
    always_ff @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_s_valid <= 1'h0;
            o_s_word <= '0;
            o_m_ready <= 1'h0;
        end else begin
            if (!o_s_valid || i_s_ready) begin
                o_s_valid <= i_src_en;
                o_s_word <= i_src_en ? acff_word_s'({i_rnd, i_rnd[11:8], i_rnd[0]}) : ~o_s_word;
            end
            o_m_ready <= i_sink_en;
        end
    end
endmodule : acff_partner
`default_nettype wire

// ==== bench/tb_top.sv ====
// self-checking bench of the channel queue with its register port and stream partner
`default_nettype none
`include "acff_regs.svh"
module tb_top
    import acff_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    // ******************************
    // signals and scoreboard state
    // ******************************
    logic i_mclk = 1'h0;
    logic i_rst_n = 1'h1;
    logic src_en = 1'h0;
    logic sink_en = 1'h0;
    logic [31:0] rnd = 32'h0;
    acff_word_s s_word;
    acff_word_s m_word;
    acff_cnt_t data_count;
    logic s_valid, s_ready, m_valid, m_ready, ovf, unf, ecc_err, hreadyout, hresp;
    logic hsel = 1'h0;
    logic hwrite = 1'h0;
    logic [1:0] htrans = 2'h0;
    logic [31:0] haddr = 32'h0;
    logic [31:0] hwdata = 32'h0;
    logic [31:0] hrdata;
    logic [31:0] rd;
    integer seed = 75;
    integer fail_count = 0;
    integer samples_checked = 0;
    int fsel = 0, esel = 0, pfull = 12, pempty = 2, skip = 2;
    logic ovf_en = 1'h1, unf_en = 1'h1, ovf_seen = 1'h0, unf_seen = 1'h0, no_word = 1'h0;
    logic ovf_exp = 1'h0, unf_exp = 1'h0;
    acff_word_s q[$];

    initial begin
        forever #2.5 i_mclk = ~i_mclk;
    end

    acff_top acff_top_inst (.i_mclk(i_mclk), .i_rst_n(i_rst_n), .i_s_word(s_word),
        .i_s_valid(s_valid), .o_s_ready(s_ready), .o_m_word(m_word), .o_m_valid(m_valid),
        .i_m_ready(m_ready), .o_data_count(data_count), .o_overflow(ovf), .o_underflow(unf),
        .o_ecc_err(ecc_err), .i_hsel(hsel), .i_haddr(haddr), .i_htrans(htrans),
        .i_hwrite(hwrite), .i_hsize(3'h2), .i_hwdata(hwdata), .i_hready(hreadyout),
        .o_hreadyout(hreadyout), .o_hrdata(hrdata), .o_hresp(hresp));
    acff_partner acff_partner_inst (.i_mclk(i_mclk), .i_rst_n(i_rst_n), .i_src_en(src_en),
        .i_sink_en(sink_en), .i_rnd(rnd), .i_s_ready(s_ready), .o_s_word(s_word),
        .o_s_valid(s_valid), .o_m_ready(m_ready));

    // ******************************
    // checking helpers
    // ******************************
    task automatic chk(input logic [36:0] seen, input logic [36:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            fail_count++;
            $display("ERROR %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : chk

    task automatic final_report();
        $display("checks %0d mismatches %0d", samples_checked, fail_count);
        if (fail_count == 0 && samples_checked > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : final_report

    // expected ready, valid and status from the selected sources and the word count
    function automatic logic rdy_fn(input int c);
        return fsel == 0 ? c < 16 : fsel == 1 ? c < `ACFF_AFULL_LVL : fsel == 2 ? c < pfull : 1'h0;
    endfunction : rdy_fn
    function automatic logic val_fn(input int c);
        return esel == 0 ? c > 0 : esel == 1 ? c > `ACFF_AEMPTY_LVL : esel == 2 ? c > pempty : 1'h0;
    endfunction : val_fn
    function automatic logic [31:0] stat_fn(input int c);
        return {18'h0, c <= pempty, c <= 1, c == 0, c >= pfull, c >= 15, c == 16, 3'h0, 5'(c)};
    endfunction : stat_fn

    // one single-word bus transfer: address phase, then data phase, zero or more waits each
    task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
        hsel <= 1'h1;
        htrans <= 2'h2;
        hwrite <= wr;
        haddr <= {24'h0, a};
        do @(posedge i_mclk); while (hreadyout !== 1'h1);
        hsel <= 1'h0;
        htrans <= 2'h0;
        hwdata <= wd;
        do @(posedge i_mclk); while (hreadyout !== 1'h1);
        rd = hrdata;
        chk(hresp, 1'h0);
        if (wr) skip = 3;
    endtask : ahb

    task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
        ahb(1'h0, a, 32'h0);
        chk(rd, exp);
    endtask : rdchk

    // sticky error bits against the events seen, then clear them
    task automatic errchk(input logic ecc);
        repeat (4) @(posedge i_mclk);
        rdchk(`ACFF_OFF_ERR, {29'h0, ecc, unf_seen, ovf_seen});
        ahb(1'h1, `ACFF_OFF_ERR, 32'h7);
        ovf_seen = 1'h0;
        unf_seen = 1'h0;
    endtask : errchk

    task automatic drain();
        src_en <= 1'h0;
        sink_en <= 1'h1;
        repeat (24) @(posedge i_mclk);
        sink_en <= 1'h0;
    endtask : drain

    // scoreboard: count, overflow and underflow flags checked every cycle, ready and valid outside skip windows, head word while valid and no_word clear
    always @(posedge i_mclk) begin
        if (i_rst_n) begin
            if (skip > 0) begin
                skip--;
            end else begin
                chk(s_ready, rdy_fn(q.size()));
                chk(m_valid, val_fn(q.size()));
            end
            chk(data_count, q.size());
            chk(ovf, ovf_exp);
            chk(unf, unf_exp);
            if (m_valid === 1'h1 && q.size() > 0 && !no_word) chk(m_word, q[0]);
            ovf_exp = s_valid && q.size() == 16 && ovf_en;
            unf_exp = m_ready && q.size() == 0 && unf_en;
            ovf_seen |= ovf_exp;
            unf_seen |= unf_exp;
            if (m_valid && m_ready) void'(q.pop_front());
            if (s_valid && s_ready) q.push_back(s_word);
            rnd <= $random(seed);
        end
    end

    // ******************************
    // tests
    // ******************************
    initial begin
        i_rst_n = 1'h0;
        repeat (6) @(posedge i_mclk);
        i_rst_n <= 1'h1;
        repeat (2) @(posedge i_mclk);
        rdchk(`ACFF_OFF_CTRL, 32'h30);
        rdchk(`ACFF_OFF_PFULL, `ACFF_PFULL_RST);
        rdchk(`ACFF_OFF_PEMPTY, `ACFF_PEMPTY_RST);
        ahb(1'h1, `ACFF_OFF_STATUS, 32'hFFFFFFFF);
        rdchk(`ACFF_OFF_STATUS, stat_fn(0));
        rdchk(8'h20, 32'h0);
        errchk(1'h0);
        $display("test registers done");
        // every ready source against every valid source, source on for 24 cycles then drained
        for (int k = 0; k < 16; k++) begin
            skip = 99;
            fsel = k % 4;
            esel = k / 4;
            pfull = 1 + ($unsigned($random(seed)) % 15);
            pempty = $unsigned($random(seed)) % 15;
            ovf_en = k < 8 || $random(seed) % 2;
            unf_en = k < 8 || $random(seed) % 2;
            ahb(1'h1, `ACFF_OFF_PFULL, pfull);
            ahb(1'h1, `ACFF_OFF_PEMPTY, pempty);
            ahb(1'h1, `ACFF_OFF_CTRL, {unf_en, ovf_en, 2'(esel), 2'(fsel)});
            src_en <= 1'h1;
            repeat (24) @(posedge i_mclk);
            rdchk(`ACFF_OFF_STATUS, stat_fn(q.size()));
            skip = 99;
            fsel = 0;
            esel = 0;
            ahb(1'h1, `ACFF_OFF_CTRL, {unf_en, ovf_en, 4'h0});
            drain();
            errchk(1'h0);
        end
        $display("test modes done");
        // random stalls on both sides, filling then emptying
        for (int n = 0; n < 400; n++) begin
            src_en <= (($random(seed) & 3) != 0) == (n < 200);
            sink_en <= (($random(seed) & 3) != 0) != (n < 200);
            @(posedge i_mclk);
        end
        drain();
        errchk(1'h0);
        $display("test random done");
        // parity fault injected into a stored word
        ovf_en = 1'h1;
        unf_en = 1'h1;
        ahb(1'h1, `ACFF_OFF_CTRL, 32'h70);
        no_word = 1'h1;
        src_en <= 1'h1;
        repeat (5) @(posedge i_mclk);
        drain();
        no_word = 1'h0;
        chk(ecc_err, 1'h1);
        errchk(1'h1);
        repeat (2) @(posedge i_mclk);
        chk(ecc_err, 1'h0);
        $display("test parity done");
        final_report();
    end

    // watchdog against a hung handshake
    initial begin
        #100000;
        fail_count++;
        $display("ERROR %0t watchdog expired", $time);
        final_report();
    end
endmodule : tb_top
`default_nettype wire

// ==== rtl/acff_pkg.sv ====
// types shared by the channel queue files
`default_nettype none
`include "acff_regs.svh"
package acff_pkg;
    // source of the write-side ready
    typedef enum logic [1:0] {ACFF_FULL, ACFF_AFULL, ACFF_PFULL} acff_fsel_e;
    // source of the read-side valid
    typedef enum logic [1:0] {ACFF_EMPTY, ACFF_AEMPTY, ACFF_PEMPTY} acff_esel_e;
    typedef logic [`ACFF_CW-1:0] acff_cnt_t;
    typedef logic [`ACFF_PW-1:0] acff_ptr_t;
    // one stored word: the sum of the selected stream signals
    typedef struct packed {
        logic [`ACFF_DW-1:0] tdata;
        logic [`ACFF_KW-1:0] tkeep;
        logic tlast;
    } acff_word_s;
    // whole state of the top module
    typedef struct packed {
        acff_fsel_e fsel;
        acff_esel_e esel;
        logic ovf_en;
        logic unf_en;
        logic inj;
        acff_cnt_t pfull_thr;
        acff_cnt_t pempty_thr;
        acff_ptr_t wr_ptr;
        acff_ptr_t rd_ptr;
        acff_cnt_t count;
        logic out_valid;
        acff_word_s out_word;
        logic s_ready;
        logic m_valid;
        logic ovf;
        logic unf;
        logic [2:0] err;
        logic hwr;
        logic [7:0] haddr;
        logic [31:0] hrdata;
        logic hready;
    } acff_state_s;
endpackage : acff_pkg
`default_nettype wire

// ==== rtl/acff_ram.sv ====
// storage array of the channel queue with a parity bit per word
`default_nettype none
`include "acff_regs.svh"
module acff_ram
    import acff_pkg::*;
(
    input wire logic i_mclk,
    input wire logic i_we,
    input wire acff_ptr_t i_waddr,
    input wire logic [$bits(acff_word_s):0] i_wdata,
    input wire acff_ptr_t i_raddr,
    output logic [$bits(acff_word_s):0] o_rdata
);
    // ************************************************
    // array
    // ************************************************
    logic [$bits(acff_word_s):0] mem [0:`ACFF_DEPTH-1];

    // synchronous write
    always_ff @(posedge i_mclk) begin
        if (i_we) begin
            mem[i_waddr] <= i_wdata;
        end
    end

    // head word is read without waiting for a clock
    assign o_rdata = mem[i_raddr];
endmodule : acff_ram
`default_nettype wire

// ==== rtl/acff_regs.svh ====
// register offsets, field positions, reset values and sizes of the channel queue
`ifndef ACFF_REGS_SVH
`define ACFF_REGS_SVH
// ************************************************
// sizes
// ************************************************
`define ACFF_DW 32
`define ACFF_KW 4
`define ACFF_PW 4
`define ACFF_CW 5
`define ACFF_DEPTH 5'h10
`define ACFF_AFULL_LVL 5'h0F
`define ACFF_AEMPTY_LVL 5'h01
// ************************************************
// register offsets, byte addresses on the low address byte
// ************************************************
`define ACFF_OFF_CTRL 8'h00
`define ACFF_OFF_PFULL 8'h04
`define ACFF_OFF_PEMPTY 8'h08
`define ACFF_OFF_STATUS 8'h0C
`define ACFF_OFF_ERR 8'h10
// ************************************************
// fields
// ************************************************
`define ACFF_CTRL_FSEL 0
`define ACFF_CTRL_ESEL 2
`define ACFF_CTRL_OVF_EN 4
`define ACFF_CTRL_UNF_EN 5
`define ACFF_CTRL_INJ 6
`define ACFF_ST_FULL 8
`define ACFF_ST_AFULL 9
`define ACFF_ST_PFULL 10
`define ACFF_ST_EMPTY 11
`define ACFF_ST_AEMPTY 12
`define ACFF_ST_PEMPTY 13
`define ACFF_ERR_OVF 0
`define ACFF_ERR_UNF 1
`define ACFF_ERR_ECC 2
// ************************************************
// reset values
// ************************************************
`define ACFF_PFULL_RST 5'h0C
`define ACFF_PEMPTY_RST 5'h02
`endif

// ==== rtl/acff_top.sv ====
// first-word fall-through queue for one stream channel with an AHB-Lite register port
// Function
// - head word shown without read request
// - ready from full, almost full, threshold
// - valid from empty, almost empty, threshold
// - word count is log2 depth plus one
// - one clock gives one count output
// - two clocks would give two counts
// - depth power of two, fixed at 16
// - same word width on both sides
// - read while empty raises underflow
// - underflow timed on read clock
// - underflow read changes nothing
// - write while full raises overflow
// - overflow timed on write clock
// - overflow write is discarded
// - overflow and underflow flags optional, parity error flag always on, any memory
// - error injection and check on storage
// - programmable full at register-set threshold
// - programmable empty at register-set threshold
// - word width is sum of fields
`default_nettype none
`include "acff_regs.svh"
module acff_top
    import acff_pkg::*;
(
    input wire logic i_mclk,
    input wire logic i_rst_n,
    input wire acff_word_s i_s_word,
    input wire logic i_s_valid,
    output logic o_s_ready,
    output acff_word_s o_m_word,
    output logic o_m_valid,
    input wire logic i_m_ready,
    output acff_cnt_t o_data_count,
    output logic o_overflow,
    output logic o_underflow,
    output logic o_ecc_err,
    input wire logic i_hsel,
    input wire logic [31:0] i_haddr,
    input wire logic [1:0] i_htrans,
    input wire logic i_hwrite,
    input wire logic [2:0] i_hsize,
    input wire logic [31:0] i_hwdata,
    input wire logic i_hready,
    output logic o_hreadyout,
    output logic [31:0] o_hrdata,
    output logic o_hresp
);
    // ************************************************
    // flag decoding
    // ************************************************
    // selected fullness indication
    function automatic logic full_ind(acff_cnt_t c, acff_fsel_e s, acff_cnt_t thr);
        unique case (s)
            ACFF_FULL: return c == `ACFF_DEPTH;
            ACFF_AFULL: return c >= `ACFF_AFULL_LVL;
            ACFF_PFULL: return c >= thr;
            default: return 1'b1;
        endcase
    endfunction : full_ind

    // selected emptiness indication
    function automatic logic empty_ind(acff_cnt_t c, acff_esel_e s, acff_cnt_t thr);
        unique case (s)
            ACFF_EMPTY: return c == 5'h00;
            ACFF_AEMPTY: return c <= `ACFF_AEMPTY_LVL;
            ACFF_PEMPTY: return c <= thr;
            default: return 1'b1;
        endcase
    endfunction : empty_ind

    // ************************************************
    // state and working signals
    // ************************************************
    acff_state_s st_reg;
    acff_state_s st_next;
    logic push;
    logic pop;
    logic to_mem;
    logic load_mem;
    logic acc;
    logic ovf_ev;
    logic unf_ev;
    logic ecc_ev;
    logic [2:0] err_clr;
    acff_cnt_t mem_cnt;
    logic [$bits(acff_word_s):0] ram_wdata;
    logic [$bits(acff_word_s):0] ram_rdata;
    logic [31:0] rd_val;

    // storage, same width on write and read side
    acff_ram u_ram (
        .i_mclk(i_mclk),
        .i_we(to_mem),
        .i_waddr(st_reg.wr_ptr),
        .i_wdata(ram_wdata),
        .i_raddr(st_reg.rd_ptr),
        .o_rdata(ram_rdata)
    );

    // parity with optional injected error
    assign ram_wdata = {(^i_s_word) ^ st_reg.inj, i_s_word};

    // register read value
    always_comb begin
        rd_val = 32'h0000_0000;
        // decoded from the address phase so the data stands through the data phase
        unique case (acc ? i_haddr[7:0] : st_reg.haddr)
            `ACFF_OFF_CTRL: begin
                rd_val[`ACFF_CTRL_FSEL +: 2] = st_reg.fsel;
                rd_val[`ACFF_CTRL_ESEL +: 2] = st_reg.esel;
                rd_val[`ACFF_CTRL_OVF_EN] = st_reg.ovf_en;
                rd_val[`ACFF_CTRL_UNF_EN] = st_reg.unf_en;
                rd_val[`ACFF_CTRL_INJ] = st_reg.inj;
            end
            `ACFF_OFF_PFULL: rd_val[`ACFF_CW-1:0] = st_reg.pfull_thr;
            `ACFF_OFF_PEMPTY: rd_val[`ACFF_CW-1:0] = st_reg.pempty_thr;
            `ACFF_OFF_STATUS: begin
                rd_val[`ACFF_CW-1:0] = st_reg.count;
                rd_val[`ACFF_ST_FULL] = full_ind(st_reg.count, ACFF_FULL, st_reg.pfull_thr);
                rd_val[`ACFF_ST_AFULL] = full_ind(st_reg.count, ACFF_AFULL, st_reg.pfull_thr);
                rd_val[`ACFF_ST_PFULL] = full_ind(st_reg.count, ACFF_PFULL, st_reg.pfull_thr);
                rd_val[`ACFF_ST_EMPTY] = empty_ind(st_reg.count, ACFF_EMPTY, st_reg.pempty_thr);
                rd_val[`ACFF_ST_AEMPTY] = empty_ind(st_reg.count, ACFF_AEMPTY,
                                                    st_reg.pempty_thr);
                rd_val[`ACFF_ST_PEMPTY] = empty_ind(st_reg.count, ACFF_PEMPTY,
                                                    st_reg.pempty_thr);
            end
            `ACFF_OFF_ERR: rd_val[2:0] = st_reg.err;
            default: rd_val = 32'h0000_0000;
        endcase
    end

    // ************************************************
    // next state
    // ************************************************
    always_comb begin
        st_next = st_reg;
        // handshakes on both sides
        push = i_s_valid && st_reg.s_ready && (st_reg.count != `ACFF_DEPTH);
        pop = st_reg.m_valid && i_m_ready;
        ovf_ev = i_s_valid && (st_reg.count == `ACFF_DEPTH);
        unf_ev = i_m_ready && (st_reg.count == 5'h00);
        mem_cnt = st_reg.count - {4'h0, st_reg.out_valid};
        load_mem = 1'b0;
        to_mem = push;
        ecc_ev = 1'b0;
        // head stage refill: from storage, else straight from the input
        if (!st_reg.out_valid || pop) begin
            if (mem_cnt != 5'h00) begin
                load_mem = 1'b1;
                st_next.out_valid = 1'b1;
                st_next.out_word = ram_rdata[$bits(acff_word_s)-1:0];
                ecc_ev = ^ram_rdata;
                st_next.rd_ptr = st_reg.rd_ptr + 4'h1;
            end else if (push) begin
                to_mem = 1'b0;
                st_next.out_valid = 1'b1;
                st_next.out_word = i_s_word;
            end else begin
                st_next.out_valid = 1'b0;
            end
        end
        if (to_mem) begin
            st_next.wr_ptr = st_reg.wr_ptr + 4'h1;
            st_next.inj = 1'b0;
        end
        // failed accesses leave pointers and count alone
        // single clock build: one count, the two-count variant is not built
        st_next.count = st_reg.count + {4'h0, push} - {4'h0, pop};
        st_next.ovf = ovf_ev && st_reg.ovf_en;
        st_next.unf = unf_ev && st_reg.unf_en;
        // bus address phase
        acc = i_hsel && i_htrans[1] && i_hready;
        st_next.hwr = acc && i_hwrite;
        st_next.haddr = acc ? i_haddr[7:0] : st_reg.haddr;
        st_next.hready = 1'b1;
        // bus data phase write
        err_clr = 3'h0;
        if (st_reg.hwr) begin
            unique case (st_reg.haddr)
                `ACFF_OFF_CTRL: begin
                    st_next.fsel = acff_fsel_e'(i_hwdata[`ACFF_CTRL_FSEL +: 2]);
                    st_next.esel = acff_esel_e'(i_hwdata[`ACFF_CTRL_ESEL +: 2]);
                    st_next.ovf_en = i_hwdata[`ACFF_CTRL_OVF_EN];
                    st_next.unf_en = i_hwdata[`ACFF_CTRL_UNF_EN];
                    st_next.inj = i_hwdata[`ACFF_CTRL_INJ];
                end
                `ACFF_OFF_PFULL: st_next.pfull_thr = i_hwdata[`ACFF_CW-1:0];
                `ACFF_OFF_PEMPTY: st_next.pempty_thr = i_hwdata[`ACFF_CW-1:0];
                `ACFF_OFF_ERR: err_clr = i_hwdata[2:0];
                default: err_clr = 3'h0;
            endcase
        end
        // sticky errors, a new event beats a clear
        st_next.err = (st_reg.err & ~err_clr) | {ecc_ev, st_next.unf, st_next.ovf};
        // read data for the next data phase
        if (acc && !i_hwrite) begin
            st_next.haddr = i_haddr[7:0];
        end
        st_next.hrdata = rd_val;
        // handshake outputs from the selected indications
        st_next.s_ready = !full_ind(st_next.count, st_next.fsel, st_next.pfull_thr);
        st_next.m_valid = st_next.out_valid
                          && !empty_ind(st_next.count, st_next.esel, st_next.pempty_thr);
    end

    // state register
    always_ff @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            st_reg <= '0;
            st_reg.ovf_en <= 1'b1;
            st_reg.unf_en <= 1'b1;
            st_reg.pfull_thr <= `ACFF_PFULL_RST;
            st_reg.pempty_thr <= `ACFF_PEMPTY_RST;
            st_reg.hready <= 1'b1;
        end else begin
            st_reg <= st_next;
        end
    end

    // ************************************************
    // outputs
    // ************************************************
    assign o_s_ready = st_reg.s_ready;
    assign o_m_word = st_reg.out_word;
    assign o_m_valid = st_reg.m_valid;
    assign o_data_count = st_reg.count;
    assign o_overflow = st_reg.ovf;
    assign o_underflow = st_reg.unf;
    assign o_ecc_err = st_reg.err[`ACFF_ERR_ECC];
    assign o_hreadyout = st_reg.hready;
    assign o_hrdata = st_reg.hrdata;
    assign o_hresp = 1'b0;

    // ************************************************
    // checks
    // ************************************************
    default clocking cb @(posedge i_mclk);
    endclocking
    default disable iff (!i_rst_n);

    // first word into an empty queue
    sequence s_first_write;
        (st_reg.count == 5'h00) && push;
    endsequence
    // head shown one edge later
    sequence s_head_shown;
        st_reg.out_valid && (o_m_word == $past(i_s_word));
    endsequence

    a_head_fall_through: assert property (s_first_write |=> s_head_shown)
        else $error("first word not shown at head");
    a_ready_plain_full: assert property ((st_reg.fsel == ACFF_FULL)
        |-> (o_s_ready == (st_reg.count != `ACFF_DEPTH) || $past(st_reg.hwr)
             || !$past(i_rst_n)))
        else $error("ready does not follow full");
    a_valid_plain_empty: assert property ((st_reg.esel == ACFF_EMPTY)
        && !$past(st_reg.hwr) |-> (o_m_valid == (st_reg.count != 5'h00)))
        else $error("valid does not follow empty");
    a_count_push_step: assert property ((push && !pop)
        |=> (st_reg.count == $past(st_reg.count) + 5'h01))
        else $error("count did not rise on write");
    a_count_depth_cap: assert property (st_reg.count <= `ACFF_DEPTH)
        else $error("count above depth");
    a_unf_flag_pulse: assert property (unf_ev && st_reg.unf_en |=> o_underflow)
        else $error("underflow not flagged");
    a_unf_no_change: assert property (unf_ev |=> $stable(st_reg.rd_ptr))
        else $error("underflow moved read pointer");
    a_ovf_flag_pulse: assert property (ovf_ev && st_reg.ovf_en |=> o_overflow)
        else $error("overflow not flagged");
    a_ovf_discard: assert property (ovf_ev && !pop
        |=> $stable(st_reg.wr_ptr) && (st_reg.count == `ACFF_DEPTH))
        else $error("overflow write was stored");
endmodule : acff_top
`default_nettype wire
